// File: pkd_alu_pkg.sv
// Purpose: shared constants and types of the packed multiply / or / shift-left datapath
// Assumes: eight packed registers of 64 bits, words of 16 bits, doublewords of 32 bits
// Notes:   fault codes are local encodings, not vector numbers
package pkd_alu_pkg;

  localparam int unsigned QW_W        = 64;
  localparam int unsigned WORD_W      = 16;
  localparam int unsigned DW_W        = 32;
  localparam int unsigned WORD_LANES  = 4;
  localparam int unsigned REG_CNT     = 8;
  localparam int unsigned REG_IDX_W   = 3;
  localparam int unsigned IMM_W       = 8;
  localparam int unsigned ADDR_W      = 32;
  localparam int unsigned OPND_BYTES  = 8;
  localparam int unsigned PROD_HI_LSB = 16;

  localparam logic [63:0] WORD_CNT_MAX = 64'h000000000000000f;
  localparam logic [63:0] DW_CNT_MAX   = 64'h000000000000001f;
  localparam logic [63:0] QW_CNT_MAX   = 64'h000000000000003f;
  localparam logic [32:0] REAL_TOP     = 33'h00000ffff;
  localparam logic [1:0]  USER_CPL     = 2'h3;
  localparam logic [2:0]  ALIGN_MASK   = 3'h7;
  localparam logic [63:0] RESULT_RST   = 64'h0000000000000000;

  typedef enum logic [2:0] {
    OP_MUL_HIGH_WORD = 3'h0,
    OP_MUL_LOW_WORD  = 3'h1,
    OP_BITWISE_OR    = 3'h2,
    OP_SHL_WORDS     = 3'h3,
    OP_SHL_DWORDS    = 3'h4,
    OP_SHL_QUAD      = 3'h5
  } alu_op_t;

  typedef enum logic [3:0] {
    FC_NONE        = 4'h0,
    FC_INVALID_OP  = 4'h1,
    FC_DEV_UNAVAIL = 4'h2,
    FC_MATH        = 4'h3,
    FC_GEN_PROT    = 4'h4,
    FC_STACK_SEG   = 4'h5,
    FC_PAGE_MISS   = 4'h6,
    FC_ALIGN_CHECK = 4'h7,
    FC_REAL_INT13  = 4'h8
  } fault_code_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_EXEC = 2'b10
  } alu_state_t;

endpackage : pkd_alu_pkg

// File: pkd_rf_if.sv
// Purpose: carrier between the datapath and its packed register store
// Assumes: read data appear one clock after the read indices
// Notes:   one write port, two read ports
`timescale 1ns/100ps
`default_nettype none
interface pkd_rf_if;
  import pkd_alu_pkg::*;
  logic                 rd_en;
  logic [REG_IDX_W-1:0] rd_dest_idx;
  logic [REG_IDX_W-1:0] rd_src_idx;
  logic [QW_W-1:0]      rd_dest_data;
  logic [QW_W-1:0]      rd_src_data;
  logic                 wr_en;
  logic [REG_IDX_W-1:0] wr_idx;
  logic [QW_W-1:0]      wr_data;

  modport alu (output rd_en, output rd_dest_idx, output rd_src_idx, input rd_dest_data,
               input rd_src_data, output wr_en, output wr_idx, output wr_data);
  modport store (input rd_en, input rd_dest_idx, input rd_src_idx, output rd_dest_data,
                 output rd_src_data, input wr_en, input wr_idx, input wr_data);
endinterface : pkd_rf_if
`default_nettype wire

// File: pkd_reg_store.sv
// Purpose: eight packed 64-bit registers, registered read data
// Assumes: a write and a read of one index in the same cycle returns the old value
// Notes:   frozen while clk_en is low
`timescale 1ns/100ps
`default_nettype none
module pkd_reg_store
  import pkd_alu_pkg::*;
(
  input  wire logic clk_sys,
  input  wire logic srst,
  input  wire logic clk_en,
  pkd_rf_if.store   rf
);

  typedef struct packed {
    logic [REG_CNT-1:0][QW_W-1:0] regs;
    logic [QW_W-1:0]              dest_data;
    logic [QW_W-1:0]              src_data;
  } store_state_t;

  store_state_t s_q;
  store_state_t s_d;

  always_comb begin
    s_d = s_q;
    if (rf.rd_en) begin
      s_d.dest_data = s_q.regs[rf.rd_dest_idx];
      s_d.src_data  = s_q.regs[rf.rd_src_idx];
    end
    if (rf.wr_en) begin
      s_d.regs[rf.wr_idx] = rf.wr_data;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      s_q <= '0;
    end else if (clk_en) begin
      s_q <= s_d;
    end
  end

  assign rf.rd_dest_data = s_q.dest_data;
  assign rf.rd_src_data  = s_q.src_data;

endmodule : pkd_reg_store
`default_nettype wire

// File: packed_mul_or_shift_left_alu.sv
// Purpose: packed multiply high/low, 64-bit or, and left shifts of words, doublewords, quadword
// Assumes: decode, segment and paging checks come from logic on clk_sys
// Notes:   one instruction at a time; result one edge after the issue edge
`timescale 1ns/100ps
`default_nettype none
module packed_mul_or_shift_left_alu
  import pkd_alu_pkg::*;
(
  input  wire logic                 clk_sys,
  input  wire logic                 srst,
  input  wire logic                 clk_en,
  input  wire logic                 issue_valid,
  input  wire alu_op_t              issue_op,
  input  wire logic [REG_IDX_W-1:0] packed_dest_register,
  input  wire logic [REG_IDX_W-1:0] src_reg_idx,
  input  wire logic                 src_is_mem,
  input  wire logic [QW_W-1:0]      mem_operand,
  input  wire logic [ADDR_W-1:0]    mem_addr,
  input  wire logic                 has_immediate,
  input  wire logic [IMM_W-1:0]     immediate_count,
  input  wire logic                 emulation_control_bit,
  input  wire logic                 task_switched_bit,
  input  wire logic                 fp_error_pending,
  input  wire logic                 protected_mode,
  input  wire logic [1:0]           cur_priv_level,
  input  wire logic                 align_check_en,
  input  wire logic                 seg_violation,
  input  wire logic                 seg_is_stack,
  input  wire logic                 page_miss,
  input  wire logic                 load_valid,
  input  wire logic [REG_IDX_W-1:0] load_idx,
  input  wire logic [QW_W-1:0]      load_data,
  output logic                      issue_ready,
  output logic                      done,
  output logic                      fault,
  output fault_code_t               fault_code,
  output logic [QW_W-1:0]           result,
  output logic                      flags_write
);

  typedef struct packed {
    alu_state_t           state;
    alu_op_t              op;
    logic [REG_IDX_W-1:0] dest_idx;
    logic                 src_is_mem;
    logic [QW_W-1:0]      mem_opnd;
    logic                 has_imm;
    logic [IMM_W-1:0]     imm;
    fault_code_t          pend_fault;
    logic                 ready;
    logic                 done;
    logic                 fault;
    fault_code_t          fault_code;
    logic [QW_W-1:0]      result;
    logic                 flags_write;
    logic                 wr_en;
    logic [REG_IDX_W-1:0] wr_idx;
    logic [QW_W-1:0]      wr_data;
    logic                 fwd_dst;
    logic                 fwd_src;
    logic [QW_W-1:0]      fwd_data;
  } alu_reg_t;

  alu_reg_t s_q;
  alu_reg_t s_d;

  pkd_rf_if rf ();

  pkd_reg_store u_store (
    .clk_sys (clk_sys),
    .srst    (srst),
    .clk_en  (clk_en),
    .rf      (rf)
  );

  // fault priority: control bits, then pending math, then memory checks
  function automatic fault_code_t check_faults(
    input logic              em,
    input logic              ts,
    input logic              mf,
    input logic              is_mem,
    input logic              pmode,
    input logic [1:0]        cpl,
    input logic              ac_en,
    input logic              seg_bad,
    input logic              stack,
    input logic              pmiss,
    input logic [ADDR_W-1:0] addr
  );
    logic [32:0] last_byte;
    last_byte = {1'b0, addr} + 33'(OPND_BYTES - 1);
    if (em) begin
      return FC_INVALID_OP;
    end else if (ts) begin
      return FC_DEV_UNAVAIL;
    end else if (mf) begin
      return FC_MATH;
    end else if (is_mem && pmode) begin
      if (seg_bad && stack) begin
        return FC_STACK_SEG;
      end else if (seg_bad) begin
        return FC_GEN_PROT;
      end else if (pmiss) begin
        return FC_PAGE_MISS;
      end else if (ac_en && cpl == USER_CPL && (addr[2:0] & ALIGN_MASK) != 3'h0) begin
        return FC_ALIGN_CHECK;
      end
      return FC_NONE;
    end else if (is_mem && last_byte > REAL_TOP) begin
      return FC_REAL_INT13;
    end
    return FC_NONE;
  endfunction : check_faults

  // store write landing on the issue edge
  function automatic logic wb_hit(
    input logic                 wr_en,
    input logic [REG_IDX_W-1:0] wr_idx,
    input logic [REG_IDX_W-1:0] rd_idx
  );
    return wr_en && (wr_idx == rd_idx);
  endfunction : wb_hit

  // store reads old data on a same-edge write, so the late value is kept aside
  function automatic logic [QW_W-1:0] bypass(
    input logic            hit,
    input logic [QW_W-1:0] late,
    input logic [QW_W-1:0] stored
  );
    logic [QW_W-1:0] pick;
    pick = stored;
    if (hit) begin
      pick = late;
    end
    return pick;
  endfunction : bypass

  // counts of the lane width or more clear the destination instead of wrapping
  function automatic logic count_over_limit(
    input alu_op_t         op,
    input logic [QW_W-1:0] cnt
  );
    logic over;
    over = 1'b0;
    case (op)
      OP_SHL_WORDS: begin
        over = (cnt > WORD_CNT_MAX);
      end
      OP_SHL_DWORDS: begin
        over = (cnt > DW_CNT_MAX);
      end
      OP_SHL_QUAD: begin
        over = (cnt > QW_CNT_MAX);
      end
      default: begin
        over = 1'b0;
      end
    endcase
    return over;
  endfunction : count_over_limit

  logic [QW_W-1:0] dst_v;
  logic [QW_W-1:0] src_v;
  logic [QW_W-1:0] count_v;
  logic [QW_W-1:0] mul_hi_v;
  logic [QW_W-1:0] mul_lo_v;
  logic [QW_W-1:0] shl_w_v;
  logic [QW_W-1:0] shl_d_v;

  assign dst_v   = bypass(s_q.fwd_dst, s_q.fwd_data, rf.rd_dest_data);
  assign src_v   = s_q.src_is_mem ? s_q.mem_opnd : bypass(s_q.fwd_src, s_q.fwd_data, rf.rd_src_data);
  assign count_v = s_q.has_imm ? {56'h0, s_q.imm} : src_v;

  genvar gl;
  generate
    for (gl = 0; gl < WORD_LANES; gl++) begin : g_word
      logic signed [DW_W-1:0] prod_s;
      logic        [DW_W-1:0] prod_u;
      assign prod_s = $signed(dst_v[gl*WORD_W +: WORD_W]) * $signed(src_v[gl*WORD_W +: WORD_W]);
      assign prod_u = dst_v[gl*WORD_W +: WORD_W] * src_v[gl*WORD_W +: WORD_W];
      assign mul_hi_v[gl*WORD_W +: WORD_W] = prod_s[PROD_HI_LSB +: WORD_W];
      assign mul_lo_v[gl*WORD_W +: WORD_W] = prod_u[WORD_W-1:0];
      assign shl_w_v[gl*WORD_W +: WORD_W]  = dst_v[gl*WORD_W +: WORD_W] << count_v[3:0];
    end
    for (gl = 0; gl < 2; gl++) begin : g_dword
      assign shl_d_v[gl*DW_W +: DW_W] = dst_v[gl*DW_W +: DW_W] << count_v[4:0];
    end
  endgenerate

  always_comb begin
    logic [QW_W-1:0] res;
    fault_code_t     fc;
    res = RESULT_RST;
    fc  = FC_NONE;
    s_d = s_q;
    s_d.done        = 1'b0;
    s_d.wr_en       = 1'b0;
    s_d.flags_write = 1'b0;
    case (s_q.state)
      ST_IDLE: begin
        if (issue_valid) begin
          s_d.op         = issue_op;
          s_d.dest_idx   = packed_dest_register;
          s_d.src_is_mem = src_is_mem;
          s_d.mem_opnd   = mem_operand;
          s_d.has_imm    = has_immediate;
          s_d.imm        = immediate_count;
          s_d.fwd_dst    = wb_hit(rf.wr_en, rf.wr_idx, packed_dest_register);
          s_d.fwd_src    = wb_hit(rf.wr_en, rf.wr_idx, src_reg_idx);
          s_d.fwd_data   = rf.wr_data;
          s_d.pend_fault = check_faults(emulation_control_bit, task_switched_bit, fp_error_pending,
                                        src_is_mem && !has_immediate, protected_mode, cur_priv_level,
                                        align_check_en, seg_violation, seg_is_stack, page_miss, mem_addr);
          s_d.ready      = 1'b0;
          s_d.state      = ST_EXEC;
        end
      end
      ST_EXEC: begin
        case (s_q.op)
          OP_MUL_HIGH_WORD: begin
            res = mul_hi_v;
          end
          OP_MUL_LOW_WORD: begin
            res = mul_lo_v;
          end
          OP_BITWISE_OR: begin
            res = dst_v | src_v;
          end
          OP_SHL_WORDS: begin
            res = count_over_limit(s_q.op, count_v) ? RESULT_RST : shl_w_v;
          end
          OP_SHL_DWORDS: begin
            res = count_over_limit(s_q.op, count_v) ? RESULT_RST : shl_d_v;
          end
          OP_SHL_QUAD: begin
            res = count_over_limit(s_q.op, count_v) ? RESULT_RST : dst_v << count_v[5:0];
          end
          default: begin
            res = dst_v;
          end
        endcase
        fc             = s_q.pend_fault;
        s_d.done       = 1'b1;
        s_d.fault      = (fc != FC_NONE);
        s_d.fault_code = fc;
        if (fc == FC_NONE) begin
          s_d.result  = res;
          s_d.wr_en   = 1'b1;
          s_d.wr_idx  = s_q.dest_idx;
          s_d.wr_data = res;
        end else begin
          s_d.result = dst_v;
        end
        s_d.ready = 1'b1;
        s_d.state = ST_IDLE;
      end
      default: begin
        s_d.state = ST_IDLE;
        s_d.ready = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      s_q       <= '0;
      s_q.state <= ST_IDLE;
      s_q.ready <= 1'b1;
    end else if (clk_en) begin
      s_q <= s_d;
    end
  end

  // loads from outside share the write port; a datapath write-back wins
  assign rf.rd_en       = (s_q.state == ST_IDLE) && issue_valid;
  assign rf.rd_dest_idx = packed_dest_register;
  assign rf.rd_src_idx  = src_reg_idx;
  assign rf.wr_en       = s_q.wr_en || load_valid;
  assign rf.wr_idx      = s_q.wr_en ? s_q.wr_idx : load_idx;
  assign rf.wr_data     = s_q.wr_en ? s_q.wr_data : load_data;

  assign issue_ready = s_q.ready;
  assign done        = s_q.done;
  assign fault       = s_q.fault;
  assign fault_code  = s_q.fault_code;
  assign result      = s_q.result;
  assign flags_write = s_q.flags_write;

endmodule : packed_mul_or_shift_left_alu
`default_nettype wire

// File: mem_unit_model.sv
// Purpose: memory unit beside the alu, operand and page status
// Assumes: operand content is a fixed function of the address
// Notes:   top half of the address space is unmapped
`timescale 1ns/100ps
`default_nettype none
module mem_unit_model (
  input  wire logic [31:0] mem_addr,
  output logic      [63:0] mem_operand,
  output logic             page_miss
);
  assign mem_operand = {mem_addr ^ 32'h5a5aa5a5, mem_addr};
  assign page_miss   = mem_addr[31];
endmodule : mem_unit_model
`default_nettype wire

// File: pkd_alu_checker.sv
// Purpose: port-level timing and fault checks of the alu
// Assumes: clk_en held high
// Notes:   bound to the top module
`timescale 1ns/100ps
`default_nettype none
module pkd_alu_checker
  import pkd_alu_pkg::*;
(
  input wire logic        clk_sys,
  input wire logic        srst,
  input wire logic        clk_en,
  input wire logic        issue_valid,
  input wire logic        issue_ready,
  input wire logic        done,
  input wire logic        fault,
  input wire fault_code_t fault_code,
  input wire logic [63:0] result,
  input wire logic        flags_write,
  input wire logic        emulation_control_bit,
  input wire logic        task_switched_bit,
  input wire logic        fp_error_pending,
  input wire logic        protected_mode,
  input wire logic        src_is_mem,
  input wire logic        has_immediate,
  input wire logic [31:0] mem_addr
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);
  logic acc;
  logic clean;
  assign acc   = clk_en && issue_valid && issue_ready;
  assign clean = !emulation_control_bit && !task_switched_bit && !fp_error_pending;
  property p_lat; acc |-> ##2 done; endproperty
  a_lat: assert property (p_lat) else $error("no done two cycles after issue");
  property p_ready; acc |=> !issue_ready ##1 issue_ready; endproperty
  a_ready: assert property (p_ready) else $error("ready not back with done");
  property p_pulse; done |=> !done; endproperty
  a_pulse: assert property (p_pulse) else $error("done wider than one cycle");
  property p_hold; !done && !srst |=> $stable(result) || done; endproperty
  a_hold: assert property (p_hold) else $error("result moved without done");
  property p_code; done |-> fault == (fault_code != FC_NONE); endproperty
  a_code: assert property (p_code) else $error("fault flag and code disagree");
  property p_flags; !flags_write; endproperty
  a_flags: assert property (p_flags) else $error("flags written");
  property p_em; acc && emulation_control_bit |-> ##2 fault_code == FC_INVALID_OP; endproperty
  a_em: assert property (p_em) else $error("emulation bit not refused");
  property p_ts; acc && !emulation_control_bit && task_switched_bit |-> ##2 fault_code == FC_DEV_UNAVAIL;
  endproperty
  a_ts: assert property (p_ts) else $error("task switch not refused");
  property p_mf;
    acc && !emulation_control_bit && !task_switched_bit && fp_error_pending |-> ##2 fault_code == FC_MATH;
  endproperty
  a_mf: assert property (p_mf) else $error("pending math error ignored");
  property p_top;
    acc && clean && !protected_mode && src_is_mem && !has_immediate && ({1'b0, mem_addr} + 33'h7 > REAL_TOP)
      |-> ##2 fault_code == FC_REAL_INT13;
  endproperty
  a_top: assert property (p_top) else $error("real mode overrun missed");
  c_ok: cover property (done && !fault);
  c_flt: cover property (done && fault);
  c_real: cover property (acc && !protected_mode && src_is_mem);
endmodule : pkd_alu_checker
bind packed_mul_or_shift_left_alu pkd_alu_checker u_chk (.clk_sys, .srst, .clk_en, .issue_valid, .issue_ready,
  .done, .fault, .fault_code, .result, .flags_write, .emulation_control_bit, .task_switched_bit,
  .fp_error_pending, .protected_mode, .src_is_mem, .has_immediate, .mem_addr);
`default_nettype wire

// File: packed_mul_or_shift_left_alu_tb.sv
// Purpose: self-checking bench of the packed alu
// Assumes: clk_en stays high
// Notes:   mirror holds the expected register contents
`timescale 1ns/100ps
`default_nettype none
module packed_mul_or_shift_left_alu_tb;
  import pkd_alu_pkg::*;
  logic        clk_sys, srst, clk_en, issue_valid, src_is_mem, has_immediate, load_valid;
  logic        emulation_control_bit, task_switched_bit, fp_error_pending, protected_mode;
  logic        align_check_en, seg_violation, seg_is_stack, page_miss;
  logic        issue_ready, done, fault, flags_write;
  alu_op_t     issue_op;
  fault_code_t fault_code;
  logic [2:0]  packed_dest_register, src_reg_idx, load_idx;
  logic [1:0]  cur_priv_level;
  logic [7:0]  immediate_count;
  logic [31:0] mem_addr;
  logic [63:0] mem_operand, load_data, result;
  logic [63:0] mirror [8] = '{default: 64'h0};
  int          miscompares, comparisons, cycles;

  packed_mul_or_shift_left_alu dut (.clk_sys, .srst, .clk_en, .issue_valid, .issue_op, .packed_dest_register,
    .src_reg_idx, .src_is_mem, .mem_operand, .mem_addr, .has_immediate, .immediate_count, .emulation_control_bit,
    .task_switched_bit, .fp_error_pending, .protected_mode, .cur_priv_level, .align_check_en, .seg_violation,
    .seg_is_stack, .page_miss, .load_valid, .load_idx, .load_data, .issue_ready, .done, .fault, .fault_code,
    .result, .flags_write);
  mem_unit_model far_end (.mem_addr, .mem_operand, .page_miss);

  task automatic chk(input logic [63:0] seen, input logic [63:0] want);
    comparisons++;
    if (seen !== want) begin
      miscompares++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, want);
    end
  endtask : chk

  task automatic wrap_up;
    if (miscompares == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : wrap_up

  function automatic logic [63:0] model(alu_op_t op, logic [63:0] d, logic [63:0] s, logic hi, logic [7:0] imm);
    logic [63:0] c, r;
    logic [31:0] p;
    c = hi ? {56'h0, imm} : s;
    r = 64'h0;
    for (int k = 0; k < 4; k++) begin
      p = $signed(d[16*k+:16]) * $signed(s[16*k+:16]);
      if (op == OP_MUL_HIGH_WORD) r[16*k+:16] = p[31:16];
      if (op == OP_MUL_LOW_WORD) r[16*k+:16] = p[15:0];
      if (op == OP_SHL_WORDS && c < 16) r[16*k+:16] = d[16*k+:16] << c[3:0];
    end
    for (int k = 0; k < 2; k++)
      if (op == OP_SHL_DWORDS && c < 32) r[32*k+:32] = d[32*k+:32] << c[4:0];
    if (op == OP_BITWISE_OR) r = d | s;
    if (op == OP_SHL_QUAD && c < 64) r = d << c[5:0];
    return r;
  endfunction : model

  task automatic load(input logic [2:0] i, input logic [63:0] v);
    @(posedge clk_sys);
    load_valid <= 1'b1;
    load_idx <= i;
    load_data <= v;
    @(posedge clk_sys);
    load_valid <= 1'b0;
    mirror[i] = v;
  endtask : load

  task automatic run(input alu_op_t op, input logic [2:0] d, input logic [2:0] s, input logic m,
                     input logic [31:0] a, input logic hi, input logic [7:0] imm, input fault_code_t ec);
    logic [63:0] want;
    int          n;
    want = mirror[d];
    if (ec == FC_NONE) want = model(op, mirror[d], m ? {a ^ 32'h5a5aa5a5, a} : mirror[s], hi, imm);
    @(posedge clk_sys);
    issue_valid <= 1'b1;
    issue_op <= op;
    packed_dest_register <= d;
    src_reg_idx <= s;
    src_is_mem <= m;
    mem_addr <= a;
    has_immediate <= hi;
    immediate_count <= imm;
    @(posedge clk_sys);
    issue_valid <= 1'b0;
    n = 0;
    do begin
      @(posedge clk_sys);
      #1;
      n++;
    end while (done !== 1'b1 && n < 4);
    chk({63'h0, done}, 64'h1);
    chk(64'(n), 64'h1);
    chk(result, want);
    chk({60'h0, fault_code}, {60'h0, ec});
    chk({63'h0, flags_write}, 64'h0);
    mirror[d] = want;
  endtask : run

  task automatic t_reset;
    @(posedge clk_sys);
    #1;
    chk(result, 64'h0);
    chk({61'h0, issue_ready, done, fault}, 64'h4);
    chk({59'h0, flags_write, fault_code}, 64'h0);
  endtask : t_reset

  task automatic t_arith;
    load(3'h1, 64'h80007fffffff0003);
    load(3'h2, 64'h80007fff0002fffd);
    load(3'h3, 64'h80007fffffff0003);
    run(OP_MUL_HIGH_WORD, 3'h1, 3'h2, 1'b0, 32'h0, 1'b0, 8'h0, FC_NONE);
    run(OP_MUL_LOW_WORD, 3'h3, 3'h2, 1'b0, 32'h0, 1'b0, 8'h0, FC_NONE);
    run(OP_MUL_HIGH_WORD, 3'h2, 3'h0, 1'b1, 32'h0000fff8, 1'b0, 8'h0, FC_NONE);
    run(OP_BITWISE_OR, 3'h3, 3'h0, 1'b1, 32'h00001230, 1'b0, 8'h0, FC_NONE);
  endtask : t_arith

  task automatic t_shift;
    logic [63:0] lim [3];
    lim = '{WORD_CNT_MAX, DW_CNT_MAX, QW_CNT_MAX};
    for (int o = 3; o <= 5; o++) begin
      for (int j = 0; j < 5; j++) begin
        load(3'h4, 64'h80014003c0050f0f);
        load(3'h5, j == 2 ? lim[o-3] + 64'h1 : lim[o-3]);
        run(alu_op_t'(o), 3'h4, 3'h5, j == 4, 32'h0, j < 2, j == 0 ? 8'h01 : 8'hff, FC_NONE);
      end
    end
  endtask : t_shift

  task automatic t_fault;
    fault_code_t codes [9];
    logic [31:0] addrs [9];
    codes = '{FC_INVALID_OP, FC_DEV_UNAVAIL, FC_MATH, FC_STACK_SEG, FC_GEN_PROT, FC_PAGE_MISS,
              FC_ALIGN_CHECK, FC_REAL_INT13, FC_NONE};
    addrs = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h80000000, 32'h00000104, 32'h0000fff9, 32'h0};
    load(3'h6, 64'h0123456789abcdef);
    for (int i = 0; i < 9; i++) begin
      @(posedge clk_sys);
      emulation_control_bit <= (i == 0);
      task_switched_bit <= (i == 1);
      fp_error_pending <= (i == 2);
      protected_mode <= (i > 2 && i < 7);
      seg_violation <= (i == 3 || i == 4);
      seg_is_stack <= (i == 3);
      cur_priv_level <= (i == 6) ? 2'h3 : 2'h0;
      align_check_en <= (i == 6);
      run(OP_BITWISE_OR, 3'h6, 3'h0, 1'b1, addrs[i], 1'b0, 8'h0, codes[i]);
    end
  endtask : t_fault

  task automatic t_chain;
    logic [63:0] first, second;
    load(3'h7, 64'h00ff00ff00ff00ff);
    first = model(OP_BITWISE_OR, mirror[7], mirror[6], 1'b0, 8'h0);
    second = model(OP_SHL_WORDS, first, first, 1'b1, 8'h04);
    @(posedge clk_sys);
    issue_valid <= 1'b1;
    issue_op <= OP_BITWISE_OR;
    packed_dest_register <= 3'h7;
    src_reg_idx <= 3'h6;
    src_is_mem <= 1'b0;
    has_immediate <= 1'b0;
    @(posedge clk_sys);
    issue_op <= OP_SHL_WORDS;
    has_immediate <= 1'b1;
    immediate_count <= 8'h04;
    @(posedge clk_sys);
    #1;
    chk({63'h0, done}, 64'h1);
    chk(result, first);
    @(posedge clk_sys);
    issue_valid <= 1'b0;
    @(posedge clk_sys);
    #1;
    chk({63'h0, done}, 64'h1);
    chk({60'h0, fault_code}, 64'h0);
    chk(result, second);
    mirror[7] = second;
  endtask : t_chain

  task automatic t_midreset;
    @(posedge clk_sys);
    srst <= 1'b1;
    @(posedge clk_sys);
    srst <= 1'b0;
    mirror = '{default: 64'h0};
    t_reset();
    run(OP_BITWISE_OR, 3'h7, 3'h7, 1'b0, 32'h0, 1'b0, 8'h0, FC_NONE);
  endtask : t_midreset

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      wrap_up();
    end
  end

  initial begin
    {srst, clk_en} = 2'b11;
    {issue_valid, src_is_mem, has_immediate, load_valid, emulation_control_bit} = 5'h0;
    {task_switched_bit, fp_error_pending, protected_mode, align_check_en, seg_violation, seg_is_stack} = 6'h0;
    issue_op = OP_MUL_HIGH_WORD;
    {packed_dest_register, src_reg_idx, load_idx, cur_priv_level, immediate_count} = 19'h0;
    mem_addr = 32'h0;
    load_data = 64'h0;
    repeat (20) @(posedge clk_sys);
    srst <= 1'b0;
    t_reset();
    t_arith();
    t_shift();
    t_fault();
    t_chain();
    t_midreset();
    wrap_up();
  end
endmodule : packed_mul_or_shift_left_alu_tb
`default_nettype wire
